// *** pkg/mcs_map.vh ***
// Constants for the command sequencer host that drives a reprogrammable
// 4M x 16 memory: register offsets, operation codes, bus codes, timing.
// Assumes a 250 MHz controller clock and a 22-bit word address bus.
`ifndef MCS_MAP_VH
`define MCS_MAP_VH

// Register byte offsets on the software port
`define MCS_REG_CTRL 8'h00
`define MCS_REG_ADDR 8'h04
`define MCS_REG_WDATA 8'h08
`define MCS_REG_STATUS 8'h0C
`define MCS_REG_RDATA 8'h10

// Operation codes written to the low bits of the control register
`define MCS_OP_RESET 3'h0
`define MCS_OP_IDREAD 3'h1
`define MCS_OP_SEC_ENTER 3'h2
`define MCS_OP_SEC_EXIT 3'h3
`define MCS_OP_PROGRAM 3'h4
`define MCS_OP_ERASE 3'h5
`define MCS_OP_ARRAY_RD 3'h6
`define MCS_OP_HW_RESET 3'h7

// Status register field positions
`define MCS_ST_BUSY 0
`define MCS_ST_DONE 1
`define MCS_ST_FAIL 2
`define MCS_ST_IDMODE 3
`define MCS_ST_SECMODE 4

// Unlock locations and values, command codes
`define MCS_UNLOCK1_ADDR 22'h000555
`define MCS_UNLOCK2_ADDR 22'h0002AA
`define MCS_UNLOCK1_DATA 16'h00AA
`define MCS_UNLOCK2_DATA 16'h0055
`define MCS_CODE_RESET 16'h00F0
`define MCS_CODE_IDREAD 16'h0090
`define MCS_CODE_SEC_ENTER 16'h0088
`define MCS_CODE_EXIT_DATA 16'h0000
`define MCS_CODE_PROGRAM 16'h00A0
`define MCS_CODE_ERASE_SETUP 16'h0080
`define MCS_CODE_ERASE 16'h0010

// Status bit positions on the memory data bus, and the top address bit
`define MCS_POLL_BIT 7
`define MCS_TOGGLE_BIT 6
`define MCS_TLIMIT_BIT 5
`define MCS_TOP_ADDR_BIT 21

// Reset values of software registers
`define MCS_ADDR_RST 22'h000000
`define MCS_WDATA_RST 16'h0000

// Timing in ns, and least-time conversion to clock cycles (rounds up)
`define MCS_CLK_NS 4
`define MCS_T_SETUP_NS 20
`define MCS_T_WP_NS 50
`define MCS_T_HOLD_NS 20
`define MCS_T_ACC_NS 120
`define MCS_T_RP_NS 500
`define MCS_SYNC_LAT 3
`define MCS_CYC(ns) (((ns) + `MCS_CLK_NS - 1) / `MCS_CLK_NS)

`endif

// *** hdl/mcs_bus_cycle.v ***
// One asynchronous memory bus cycle, write or read, on the chip select,
// write strobe and output strobe pins. Assumes one clock, sync reset.
`timescale 1ns/100ps
`default_nettype none
`include "mcs_map.vh"

module mcs_bus_cycle #(
    parameter ADDR_W = 22,
    parameter DATA_W = 16
) (
    // Clock and reset
    input wire clock_in,
    input wire sys_rst_in,
    // Request side
    input wire start_in,
    input wire write_in,
    input wire abort_in,
    input wire [ADDR_W-1:0] addr_in,
    input wire [DATA_W-1:0] data_in,
    output wire busy_out,
    output reg done_out,
    output reg [DATA_W-1:0] rdata_out,
    // Memory pins
    output reg [ADDR_W-1:0] mem_addr_out,
    output reg [DATA_W-1:0] mem_dq_out,
    output reg mem_dq_oe_out,
    input wire [DATA_W-1:0] mem_dq_in,
    output reg mem_ce_n_out,
    output reg mem_we_n_out,
    output reg mem_oe_n_out
);
    localparam [1:0] C_IDLE = 2'd0;
    localparam [1:0] C_SETUP = 2'd1;
    localparam [1:0] C_PULSE = 2'd2;
    localparam [1:0] C_HOLD = 2'd3;
    localparam integer SETUP_INT = `MCS_CYC(`MCS_T_SETUP_NS);
    localparam integer WP_INT = `MCS_CYC(`MCS_T_WP_NS);
    localparam integer HOLD_INT = `MCS_CYC(`MCS_T_HOLD_NS);
    // Sync latency is added so the sampled word is past the synchroniser
    localparam integer RD_INT = `MCS_CYC(`MCS_T_ACC_NS) + `MCS_SYNC_LAT;
    localparam [7:0] SETUP_CYC = SETUP_INT[7:0];
    localparam [7:0] WP_CYC = WP_INT[7:0];
    localparam [7:0] HOLD_CYC = HOLD_INT[7:0];
    localparam [7:0] RD_CYC = RD_INT[7:0];

    reg [1:0] st_reg;
    reg [7:0] cnt_reg;
    reg wr_reg;
    reg [DATA_W-1:0] s1_reg, s2_reg, s3_reg, stable_reg;

    assign busy_out = (st_reg != C_IDLE);

    // Pin synchroniser; a change counts once stages two and three agree
    always @(posedge clock_in)
    begin
        s1_reg <= mem_dq_in;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        if (sys_rst_in)
            stable_reg <= {DATA_W{1'b0}};
        else if (s2_reg == s3_reg)
            stable_reg <= s3_reg;
    end

    // Address settles before the strobe falls, data held past its rise
    always @(posedge clock_in)
    begin
        if (sys_rst_in || abort_in)
        begin
            st_reg <= C_IDLE;
            cnt_reg <= 8'h00;
            wr_reg <= 1'b0;
            done_out <= 1'b0;
            mem_dq_oe_out <= 1'b0;
            mem_ce_n_out <= 1'b1;
            mem_we_n_out <= 1'b1;
            mem_oe_n_out <= 1'b1;
        end
        else
        begin
            done_out <= 1'b0;
            case (st_reg)
                C_IDLE:
                    if (start_in)
                    begin
                        wr_reg <= write_in;
                        mem_dq_oe_out <= write_in;
                        mem_ce_n_out <= 1'b0;
                        cnt_reg <= SETUP_CYC - 8'h01;
                        st_reg <= C_SETUP;
                    end
                C_SETUP:
                    if (cnt_reg == 8'h00)
                    begin
                        mem_we_n_out <= ~wr_reg;
                        mem_oe_n_out <= wr_reg;
                        cnt_reg <= (wr_reg ? WP_CYC : RD_CYC) - 8'h01;
                        st_reg <= C_PULSE;
                    end
                    else
                        cnt_reg <= cnt_reg - 8'h01;
                C_PULSE:
                    if (cnt_reg == 8'h00)
                    begin
                        mem_we_n_out <= 1'b1; // Data latched on this rise
                        mem_oe_n_out <= 1'b1;
                        cnt_reg <= HOLD_CYC - 8'h01;
                        st_reg <= C_HOLD;
                    end
                    else
                        cnt_reg <= cnt_reg - 8'h01;
                C_HOLD:
                    if (cnt_reg == 8'h00)
                    begin
                        mem_ce_n_out <= 1'b1;
                        mem_dq_oe_out <= 1'b0;
                        done_out <= 1'b1;
                        st_reg <= C_IDLE;
                    end
                    else
                        cnt_reg <= cnt_reg - 8'h01;
                default:
                    st_reg <= C_IDLE;
            endcase
        end
    end

    // Address, write data and read result registers
    always @(posedge clock_in)
    begin
        if (sys_rst_in)
        begin
            mem_addr_out <= {ADDR_W{1'b0}};
            mem_dq_out <= {DATA_W{1'b0}};
            rdata_out <= {DATA_W{1'b0}};
        end
        else
        begin
            if (st_reg == C_IDLE && start_in)
            begin
                mem_addr_out <= addr_in;
                mem_dq_out <= data_in;
            end
            if (st_reg == C_PULSE && cnt_reg == 8'h00 && !wr_reg)
                rdata_out <= stable_reg;
        end
    end
endmodule // mcs_bus_cycle
`default_nettype wire

// *** hdl/mcs_sequencer.v ***
// Host-side command sequencer for a reprogrammable 4M x 16 memory.
// Software orders operations over a plain register port; the block emits
// the unlock and command write cycles and polls for completion.
// Assumes the memory pins are wired straight to the mem_* ports.
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "mcs_map.vh"

module mcs_sequencer #(
    parameter ADDR_W = 22,
    parameter DATA_W = 16
) (
    // Clock and reset
    input wire clock_in,
    input wire sys_rst_in,
    // Software register port
    input wire [7:0] reg_addr_in,
    input wire [31:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [31:0] reg_rdata_out,
    // Memory pins
    output wire [ADDR_W-1:0] mem_addr_out,
    output wire [DATA_W-1:0] mem_dq_out,
    output wire mem_dq_oe_out,
    input wire [DATA_W-1:0] mem_dq_in,
    output wire mem_ce_n_out,
    output wire mem_we_n_out,
    output wire mem_oe_n_out,
    output wire mem_rst_n_out
);
    localparam [2:0] PH_IDLE = 3'd0;
    localparam [2:0] PH_WR = 3'd1;
    localparam [2:0] PH_RD = 3'd2;
    localparam [2:0] PH_POLL = 3'd3;
    localparam [2:0] PH_FAILRST = 3'd4;
    localparam [2:0] PH_HWRST = 3'd5;
    localparam integer RP_INT = `MCS_CYC(`MCS_T_RP_NS);
    localparam [7:0] RP_CYC = RP_INT[7:0];

    reg [2:0] phase_reg;
    reg [2:0] op_reg;
    reg [2:0] step_reg;
    reg wait_reg;
    reg start_reg;
    reg [ADDR_W-1:0] cyc_addr_reg;
    reg [DATA_W-1:0] cyc_data_reg;
    reg cyc_wr_reg;
    reg [ADDR_W-1:0] addr_reg;
    reg [DATA_W-1:0] wdata_reg;
    reg [DATA_W-1:0] rdata_reg;
    reg [DATA_W-1:0] prev_reg;
    reg have_prev_reg;
    reg tlimit_seen_reg;
    reg done_reg;
    reg fail_reg;
    reg id_mode_reg;
    reg sec_mode_reg;
    reg [7:0] rst_cnt_reg;
    reg rst_n_reg;
    wire cyc_busy;
    wire cyc_done;
    wire [DATA_W-1:0] cyc_rdata;
    wire ctrl_wr;
    wire [2:0] new_op;
    wire toggling;

    // Number of write cycles in each sequence
    function [2:0] seq_len;
        input [2:0] op;
        begin
            case (op)
                `MCS_OP_RESET: seq_len = 3'd1;
                `MCS_OP_SEC_EXIT: seq_len = 3'd4;
                `MCS_OP_PROGRAM: seq_len = 3'd4;
                `MCS_OP_ERASE: seq_len = 3'd6;
                default: seq_len = 3'd3;
            endcase
        end
    endfunction

    // Address of write cycle number st of operation op
    function [ADDR_W-1:0] seq_addr;
        input [2:0] op;
        input [2:0] st;
        input [ADDR_W-1:0] ua;
        reg [ADDR_W-1:0] a;
        begin
            a = `MCS_UNLOCK1_ADDR;
            if (op == `MCS_OP_RESET)
                a = ua; // Any address will do
            else if (st == 3'd1 || st == 3'd4)
                a = `MCS_UNLOCK2_ADDR;
            else if (st == 3'd3 && op != `MCS_OP_ERASE)
                a = ua; // Program target in any order
            // Top bit low in cycles three and four, target excepted
            if ((st == 3'd2 || st == 3'd3) && op != `MCS_OP_RESET &&
                !(st == 3'd3 && op == `MCS_OP_PROGRAM))
                a[`MCS_TOP_ADDR_BIT] = 1'b0;
            seq_addr = a;
        end
    endfunction

    // Data of write cycle number st of operation op
    function [DATA_W-1:0] seq_data;
        input [2:0] op;
        input [2:0] st;
        input [DATA_W-1:0] ud;
        begin
            seq_data = `MCS_UNLOCK1_DATA;
            if (op == `MCS_OP_RESET)
                seq_data = `MCS_CODE_RESET;
            else
                case (st)
                    3'd1, 3'd4: seq_data = `MCS_UNLOCK2_DATA;
                    3'd2:
                        case (op)
                            `MCS_OP_SEC_ENTER: seq_data = `MCS_CODE_SEC_ENTER;
                            `MCS_OP_PROGRAM: seq_data = `MCS_CODE_PROGRAM;
                            `MCS_OP_ERASE: seq_data = `MCS_CODE_ERASE_SETUP;
                            default: seq_data = `MCS_CODE_IDREAD;
                        endcase
                    3'd3:
                        if (op == `MCS_OP_PROGRAM)
                            seq_data = ud;
                        else if (op == `MCS_OP_SEC_EXIT)
                            seq_data = `MCS_CODE_EXIT_DATA;
                    3'd5: seq_data = `MCS_CODE_ERASE;
                    default: seq_data = `MCS_UNLOCK1_DATA;
                endcase
        end
    endfunction

    assign ctrl_wr = reg_wr_in && (reg_addr_in == `MCS_REG_CTRL);
    assign new_op = reg_wdata_in[2:0];
    assign toggling = (cyc_rdata[`MCS_TOGGLE_BIT] != prev_reg[`MCS_TOGGLE_BIT]);
    // Reset pin comes from a flop: a decoded phase could glitch it low
    assign mem_rst_n_out = rst_n_reg;

    mcs_bus_cycle #(
        .ADDR_W(ADDR_W),
        .DATA_W(DATA_W)
    ) u_mcs_bus_cycle (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .start_in(start_reg),
        .write_in(cyc_wr_reg),
        .abort_in(phase_reg == PH_HWRST),
        .addr_in(cyc_addr_reg),
        .data_in(cyc_data_reg),
        .busy_out(cyc_busy),
        .done_out(cyc_done),
        .rdata_out(cyc_rdata),
        .mem_addr_out(mem_addr_out),
        .mem_dq_out(mem_dq_out),
        .mem_dq_oe_out(mem_dq_oe_out),
        .mem_dq_in(mem_dq_in),
        .mem_ce_n_out(mem_ce_n_out),
        .mem_we_n_out(mem_we_n_out),
        .mem_oe_n_out(mem_oe_n_out)
    );

    // Pin held low while the hardware reset phase lasts
    always @(posedge clock_in)
    begin
        if (sys_rst_in)
            rst_n_reg <= 1'b1;
        else
            rst_n_reg <= (phase_reg != PH_HWRST);
    end

    // Software-written operands
    always @(posedge clock_in)
    begin
        if (sys_rst_in)
        begin
            addr_reg <= `MCS_ADDR_RST;
            wdata_reg <= `MCS_WDATA_RST;
        end
        else if (reg_wr_in)
        begin
            if (reg_addr_in == `MCS_REG_ADDR)
                addr_reg <= reg_wdata_in[ADDR_W-1:0];
            if (reg_addr_in == `MCS_REG_WDATA)
                wdata_reg <= reg_wdata_in[DATA_W-1:0];
        end
    end

    // Register read port, answer stands one cycle after the strobe
    always @(posedge clock_in)
    begin
        if (sys_rst_in)
            reg_rdata_out <= 32'h00000000;
        else if (!reg_rd_in)
            reg_rdata_out <= 32'h00000000;
        else
            case (reg_addr_in)
                `MCS_REG_ADDR: reg_rdata_out <= {10'h000, addr_reg};
                `MCS_REG_WDATA: reg_rdata_out <= {16'h0000, wdata_reg};
                `MCS_REG_STATUS: reg_rdata_out <= {27'h0000000, sec_mode_reg,
                    id_mode_reg, fail_reg, done_reg, phase_reg != PH_IDLE};
                `MCS_REG_RDATA: reg_rdata_out <= {16'h0000, rdata_reg};
                default: reg_rdata_out <= 32'h00000000;
            endcase
    end

    // Sequencer: issues cycles, polls status bits, tracks device mode.
    // Orders other than hardware reset are ignored while busy, since the
    // device ignores commands during its algorithms anyway
    always @(posedge clock_in)
    begin
        if (sys_rst_in)
        begin
            phase_reg <= PH_IDLE;
            op_reg <= `MCS_OP_RESET;
            step_reg <= 3'd0;
            wait_reg <= 1'b0;
            start_reg <= 1'b0;
            cyc_addr_reg <= {ADDR_W{1'b0}};
            cyc_data_reg <= {DATA_W{1'b0}};
            cyc_wr_reg <= 1'b0;
            rdata_reg <= {DATA_W{1'b0}};
            prev_reg <= {DATA_W{1'b0}};
            have_prev_reg <= 1'b0;
            tlimit_seen_reg <= 1'b0;
            done_reg <= 1'b0;
            fail_reg <= 1'b0;
            id_mode_reg <= 1'b0; // Device starts in array read
            sec_mode_reg <= 1'b0;
            rst_cnt_reg <= 8'h00;
        end
        else
        begin
            start_reg <= 1'b0;
            if (ctrl_wr && (phase_reg == PH_IDLE ||
                new_op == `MCS_OP_HW_RESET))
            begin
                op_reg <= new_op;
                step_reg <= 3'd0;
                wait_reg <= 1'b0;
                have_prev_reg <= 1'b0;
                tlimit_seen_reg <= 1'b0;
                done_reg <= 1'b0;
                fail_reg <= 1'b0;
                rst_cnt_reg <= RP_CYC - 8'h01;
                case (new_op)
                    `MCS_OP_HW_RESET: phase_reg <= PH_HWRST;
                    `MCS_OP_ARRAY_RD: phase_reg <= PH_RD;
                    default: phase_reg <= PH_WR;
                endcase
            end
            else if (phase_reg == PH_HWRST)
            begin
                // Device drops all modes under its reset pin
                if (rst_cnt_reg == 8'h00)
                begin
                    phase_reg <= PH_IDLE;
                    done_reg <= 1'b1;
                    id_mode_reg <= 1'b0;
                    sec_mode_reg <= 1'b0;
                end
                else
                    rst_cnt_reg <= rst_cnt_reg - 8'h01;
            end
            else if (phase_reg != PH_IDLE && !wait_reg && !cyc_busy)
            begin
                // Launch the next cycle of the current phase
                start_reg <= 1'b1;
                wait_reg <= 1'b1;
                cyc_wr_reg <= (phase_reg == PH_WR || phase_reg == PH_FAILRST);
                cyc_addr_reg <= seq_addr(op_reg, step_reg, addr_reg);
                cyc_data_reg <= seq_data(op_reg, step_reg, wdata_reg);
                if (phase_reg == PH_FAILRST)
                    cyc_data_reg <= `MCS_CODE_RESET;
                if (phase_reg == PH_RD && op_reg == `MCS_OP_IDREAD)
                    cyc_addr_reg <= {1'b0, addr_reg[ADDR_W-2:0]};
                else if (phase_reg == PH_RD || phase_reg == PH_POLL)
                    cyc_addr_reg <= addr_reg; // Poll at program address
            end
            else if (cyc_done && wait_reg)
            begin
                wait_reg <= 1'b0;
                case (phase_reg)
                    PH_WR:
                        if (step_reg + 3'd1 == seq_len(op_reg))
                        begin
                            step_reg <= 3'd0;
                            if (op_reg == `MCS_OP_IDREAD)
                                phase_reg <= PH_RD; // Code read
                            else if (op_reg == `MCS_OP_PROGRAM ||
                                     op_reg == `MCS_OP_ERASE)
                                phase_reg <= PH_POLL;
                            else
                            begin
                                phase_reg <= PH_IDLE;
                                done_reg <= 1'b1;
                                // Reset leaves identification
                                if (op_reg == `MCS_OP_RESET)
                                    id_mode_reg <= 1'b0;
                                if (op_reg == `MCS_OP_SEC_ENTER)
                                    sec_mode_reg <= 1'b1;
                                if (op_reg == `MCS_OP_SEC_EXIT)
                                    sec_mode_reg <= 1'b0;
                            end
                        end
                        else
                            step_reg <= step_reg + 3'd1;
                    PH_RD:
                    begin
                        rdata_reg <= cyc_rdata;
                        phase_reg <= PH_IDLE;
                        done_reg <= 1'b1;
                        if (op_reg == `MCS_OP_IDREAD)
                            id_mode_reg <= 1'b1; // Stays until reset
                    end
                    PH_POLL:
                    begin
                        rdata_reg <= cyc_rdata;
                        prev_reg <= cyc_rdata;
                        have_prev_reg <= 1'b1;
                        if (have_prev_reg && !toggling)
                        begin
                            // Toggling stopped: device back in array read
                            phase_reg <= PH_IDLE;
                            done_reg <= 1'b1;
                        end
                        else if (have_prev_reg && tlimit_seen_reg)
                        begin
                            phase_reg <= PH_FAILRST;
                            fail_reg <= 1'b1;
                        end
                        else if (have_prev_reg)
                            tlimit_seen_reg <= cyc_rdata[`MCS_TLIMIT_BIT];
                    end
                    PH_FAILRST:
                    begin
                        phase_reg <= PH_IDLE; // Reset written after failure
                        done_reg <= 1'b1;
                    end
                    default:
                        phase_reg <= PH_IDLE;
                endcase
            end
        end
    end
endmodule // mcs_sequencer
`default_nettype wire

// *** tb/mcs_sequencer_props.sv ***
// Pin checker for the sequencer's memory side.
// Assumes a bind to mcs_sequencer at its default widths.
`timescale 1ns/100ps
`default_nettype none
module mcs_seq_props (
    // Clock, reset and memory pins
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic [21:0] mem_addr_out,
    input wire logic [15:0] mem_dq_out,
    input wire logic mem_dq_oe_out,
    input wire logic mem_ce_n_out,
    input wire logic mem_we_n_out,
    input wire logic mem_oe_n_out,
    input wire logic mem_rst_n_out
);
    default clocking @(posedge clock_in);
    endclocking
    default disable iff (sys_rst_in);
    // Strobe pairing, so no cycle is misread as a write, then write timing, code-cycle top bit and reset pulse width
    chk_we_in_ce: assert property (!mem_we_n_out |-> !mem_ce_n_out)
        else $error("write strobe outside select");
    chk_we_no_oe: assert property (!mem_we_n_out |-> mem_oe_n_out)
        else $error("write and read overlap");
    chk_dq_driven: assert property (!mem_we_n_out |-> mem_dq_oe_out)
        else $error("word not driven in write");
    chk_no_fight: assert property (!mem_oe_n_out |-> !mem_dq_oe_out)
        else $error("host drives during read");
    chk_wr_stable: assert property (!mem_we_n_out && !$past(mem_we_n_out)
        |-> $stable(mem_addr_out) && $stable(mem_dq_out))
        else $error("address or word moved in write");
    chk_we_width: assert property ($fell(mem_we_n_out)
        |-> !$past(mem_ce_n_out) ##1 !mem_we_n_out[*8])
        else $error("write pulse too short");
    chk_code_top0: assert property (
        !mem_we_n_out && mem_addr_out[10:0] == 11'h555 |-> !mem_addr_out[21])
        else $error("top bit high in code cycle");
    chk_rst_pulse: assert property ($fell(mem_rst_n_out)
        |-> !mem_rst_n_out[*8])
        else $error("pin reset pulse too short");
endmodule // mcs_seq_props
bind mcs_sequencer mcs_seq_props u_mcs_seq_props (.*);
`default_nettype wire

// *** tb/mcs_dev_model.sv ***
// Behavioural model of the 4M x 16 memory on its pins.
// Assumes the host holds address and word across each strobe.
`timescale 1ns/100ps
`default_nettype none
module mcs_dev_model #(
    parameter logic [15:0] MAKER = 16'h005A, // Arbitrary value
    parameter logic [15:0] PART = 16'h1234 // Arbitrary value
) (
    // Pins, then knobs: reads until done, stuck time limit
    input wire logic [21:0] addr_in,
    input wire logic [15:0] dq_in,
    input wire logic ce_n_in,
    input wire logic we_n_in,
    input wire logic oe_n_in,
    input wire logic rst_n_in,
    output logic [15:0] dq_out,
    input wire logic [3:0] busy_reads_in,
    input wire logic tlim_in
);
    logic [15:0] mem [logic [21:0]];
    logic [15:0] rv = 0, pd = 0;
    logic [21:0] pa;
    logic [7:0] step = 0, nx;
    logic busy = 0, idm = 0, sec = 0, tog = 0, ers = 0;
    int left;
    wire logic at5 = addr_in[10:0] == 11'h555;
    wire logic u1 = at5 && dq_in == 16'h00AA;
    wire logic u2 = addr_in[10:0] == 11'h2AA && dq_in == 16'h0055;
    wire logic f0 = dq_in[7:0] == 8'hF0 && step != 8'hA0;
    // Released lines show the inverse of the last word
    assign dq_out = oe_n_in ? ~rv : rv;
    task automatic go(input bit ok, input bit er);
        busy = ok;
        ers = er;
        pa = addr_in;
        pd = dq_in;
        left = busy_reads_in;
    endtask
    // Word taken at strobe rise; busy ignores all writes but a reset code while the time limit is set
    always @(posedge we_n_in)
    begin
        if (!ce_n_in && rst_n_in && (!busy || tlim_in && f0))
        begin
            nx = 0; // Misfits fall back to read
            if (step == 8'h90 && dq_in == 16'h0000)
                {sec, idm} = 0;
            if (f0)
                {busy, idm} = 0;
            else
                case (step)
                8'h01: nx = u2 ? 8'h02 : 8'h00;
                8'h02: nx = at5 ? dq_in[7:0] : 8'h00;
                8'h80: nx = u1 ? 8'h81 : 8'h00;
                8'h81: nx = u2 ? 8'h82 : 8'h00;
                8'h82: go(at5 && dq_in[7:0] == 8'h10, 1'b1);
                8'hA0: go(!sec, 1'b0); // Locked sector
                default: nx = u1 ? 8'h01 : 8'h00;
                endcase
            step = nx;
            idm |= nx == 8'h90;
            sec |= nx == 8'h88;
        end
    end
    // Busy reads toggle and report status
    always @(negedge oe_n_in)
    begin
        if (busy && !tlim_in && left == 0)
        begin
            if (ers)
                mem.delete();
            else
                mem[pa] = (mem.exists(pa) ? mem[pa] : 16'hFFFF) & pd;
            busy = 0;
        end
        if (busy)
        begin
            left--;
            tog = !tog;
            rv = {8'h00, !ers && !pd[7], tog, tlim_in, 5'h00};
        end
        else if (idm)
            rv = !addr_in[1:0] ? MAKER : addr_in[1] ? 16'h0008 : PART;
        else
            rv = mem.exists(addr_in) ? mem[addr_in] : 16'hFFFF;
    end
    // Pin reset drops any operation unwritten
    always @(negedge rst_n_in)
        {step, busy, idm, sec} = 0;
endmodule // mcs_dev_model
`default_nettype wire

// *** tb/tb_mcs_sequencer.sv ***
// Bench: software port tasks run operations against the memory model.
// Assumes the sequencer at default widths and a 250 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module tb_mcs_sequencer;
    logic clock_in = 0, sys_rst_in = 1, reg_wr_in = 0, reg_rd_in = 0;
    logic tlim = 0, mem_dq_oe_out, mem_ce_n_out, mem_we_n_out;
    logic mem_oe_n_out, mem_rst_n_out;
    logic [7:0] reg_addr_in = 0;
    logic [31:0] reg_wdata_in = 0, reg_rdata_out, st;
    logic [21:0] mem_addr_out;
    logic [15:0] mem_dq_out, mem_dq_in, mq;
    logic [3:0] brd = 1;
    int n_fail = 0, n_checks = 0;
    logic [21:0] pa [4] = '{22'h212345, 22'h100, 22'h212345, 22'h200};
    logic [15:0] pd [4] = '{16'hA5A5, 16'h3C3C, 16'h5A5F, 16'h0};
    logic [15:0] pe [4] = '{16'hA5A5, 16'h3C3C, 16'h0005, 16'hFFFF};
    logic [15:0] iv [3] = '{16'h005A, 16'h1234, 16'h0008};
    always #2 clock_in = !clock_in;
    assign mem_dq_in = mem_dq_oe_out ? mem_dq_out : mq;
    mcs_sequencer u_mcs_sequencer (.*);
    mcs_dev_model u_mcs_dev_model (.addr_in(mem_addr_out),
        .dq_in(mem_dq_in), .ce_n_in(mem_ce_n_out), .we_n_in(mem_we_n_out),
        .oe_n_in(mem_oe_n_out), .rst_n_in(mem_rst_n_out), .dq_out(mq),
        .busy_reads_in(brd), .tlim_in(tlim));
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1;
        @(posedge clock_in);
        reg_wr_in <= 0;
    endtask
    // Read, optionally compare; data stands only one cycle
    task automatic rd(input logic [7:0] a, input logic [31:0] e, bit c);
        @(posedge clock_in);
        reg_addr_in <= a;
        reg_rd_in <= 1;
        @(posedge clock_in);
        reg_rd_in <= 0;
        #1 st = reg_rdata_out;
        n_checks += c;
        if (c && st !== e)
        begin
            n_fail++;
            $display("MISMATCH reg %h exp %h got %h", a, e, st);
        end
    endtask
    task automatic op(input logic [21:0] a, logic [15:0] d, logic [2:0] c);
        wr(8'h04, {10'h0, a});
        wr(8'h08, {16'h0, d});
        wr(8'h00, {29'h0, c});
        st = 1;
        repeat (3000) if (st[0]) rd(8'h0C, 0, 0);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge clock_in);
        sys_rst_in <= 0;
        rd(8'h0C, 0, 1);
        rd(8'h14, 0, 1);
        foreach (iv[i])
        begin
            op(22'h200000 | 22'(i + i / 2), 0, 3'h1);
            rd(8'h10, iv[i], 1);
        end
        rd(8'h0C, 32'hA, 1);
        op(0, 0, 3'h0);
        rd(8'h0C, 32'h2, 1);
        foreach (pa[i])
        begin
            brd <= 4'(1 + 4 * i);
            tlim <= i == 3;
            op(pa[i], pd[i], 3'h4);
            rd(8'h0C, i == 3 ? 32'h6 : 32'h2, 1);
            tlim <= 0;
            op(pa[i], 0, 3'h6);
            rd(8'h10, pe[i], 1);
        end
        // Pin reset in mid-program, word left as it was
        brd <= 15;
        wr(8'h04, 22'h300);
        wr(8'h00, 4);
        repeat (400) @(posedge clock_in);
        op(22'h300, 0, 3'h7);
        op(22'h300, 0, 3'h6);
        rd(8'h10, 32'hFFFF, 1);
        brd <= 2;
        op(0, 0, 3'h5);
        op(22'h212345, 0, 3'h6);
        rd(8'h10, 32'hFFFF, 1);
        op(0, 0, 3'h2);
        rd(8'h0C, 32'h12, 1);
        op(0, 0, 3'h3);
        rd(8'h0C, 32'h2, 1);
        close_out;
    end
    // Run is near 4k cycles; cut a hang well above that
    initial
    begin
        #300000;
        n_fail++;
        close_out;
    end
endmodule // tb_mcs_sequencer
`default_nettype wire
